// [rtl/acs_pkg.sv]
// Constants, types and helper functions of the conversion sequencer.
package acs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] ACS_OFF_CTRL1  = 8'h00;
    localparam logic [7:0] ACS_OFF_CTRL2  = 8'h04;
    localparam logic [7:0] ACS_OFF_RESULT = 8'h08;
    localparam logic [7:0] ACS_OFF_TPRE   = 8'h0C;

    ////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int ACS_C1_BUSY   = 0;
    localparam int ACS_C1_DONE   = 1;
    localparam int ACS_C1_IE     = 2;
    localparam int ACS_C1_CH_LSB = 3;
    localparam int ACS_C2_AZ     = 0;
    localparam int ACS_C2_ISRC   = 1;
    localparam int ACS_C2_DIV    = 2;
    localparam int ACS_C2_AUTO   = 4;
    localparam int ACS_C2_AMP    = 5;
    localparam int ACS_TP_FAST_CLOCK_MODE  = 0;
    localparam int ACS_TP_FAST_CLOCK_SELECT   = 1;
    localparam int ACS_TP_FS     = 2;
    localparam int ACS_TP_PS     = 3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [5:0] ACS_CTRL2_RST  = 6'h00;
    localparam logic [5:0] ACS_TPRE_RST   = 6'h00;
    localparam logic [7:0] ACS_RESULT_RST = 8'h00;
    localparam logic [2:0] ACS_CH_RST     = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Phase lengths in conversion cycles.
    localparam logic [4:0] ACS_SH_CYC  = 5'h04;
    localparam logic [4:0] ACS_OFS_CYC = 5'h06;
    localparam logic [4:0] ACS_GC_CYC  = 5'h05;
    localparam logic [4:0] ACS_CNV_CYC = 5'h09;
    localparam logic [7:0] ACS_SAR_MSB = 8'h80;

    typedef enum logic [2:0] {
        ACS_IDLE, ACS_DELAY, ACS_OFFSET, ACS_GAINC,
        ACS_SAMPLE, ACS_CONVERT, ACS_FINISH
    } acs_state_e;

    typedef struct packed {
        logic       auto_mode;
        logic       az;
        logic [1:0] div;
        logic       fast_clock_mode;
        logic       fast_clock_select;
        logic       fs;
        logic [2:0] ch;
    } acs_cfg_s;

    // Last cycle index of a timed phase.
    function automatic logic [4:0] acs_plen(acs_state_e s);
        case (s)
            ACS_OFFSET:  acs_plen = 5'(ACS_OFS_CYC - 5'h01);
            ACS_GAINC:   acs_plen = 5'(ACS_GC_CYC - 5'h01);
            ACS_SAMPLE:  acs_plen = 5'(ACS_SH_CYC - 5'h01);
            ACS_CONVERT: acs_plen = 5'(ACS_CNV_CYC - 5'h01);
            default:     acs_plen = 5'h00;
        endcase
    endfunction

    // Log2 of the total source divide; the prescale bits play no part.
    function automatic logic [3:0] acs_shift(acs_cfg_s c);
        logic [3:0] base;
        base = 4'h0;
        if (c.auto_mode) begin
            if (c.fast_clock_mode) begin
                base = c.fs ? 4'h2 : 4'h3;
            end else begin
                base = c.fast_clock_select ? 4'h1 : 4'h0;
            end
        end
        acs_shift = 4'(base + {2'b00, c.div});
    endfunction

endpackage

// [rtl/acs_tick_div.sv]
// Conversion clock divider producing a one-cycle conversion tick.
`timescale 1ns/1ps
module acs_tick_div
    import acs_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       src_tick,
    input  wire logic [3:0] shift,
    output logic            tick_r
);
    logic [6:0] cnt_r;
    wire  [6:0] term = 7'((7'h01 << shift) - 7'h01);
    wire        wrap = src_tick && (cnt_r == term);

    // Clearing while idle aligns the first cycle with the trigger.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 7'h00;
            tick_r <= 1'b0;
        end else if (clear) begin
            cnt_r  <= 7'h00;
            tick_r <= 1'b0;
        end else begin
            tick_r <= wrap;
            if (src_tick) begin
                cnt_r <= wrap ? 7'h00 : 7'(cnt_r + 7'h01);
            end
        end
    end
endmodule

// [rtl/acs_sequencer.sv]
// Conversion sequencer top with APB register file and phase control.
`timescale 1ns/1ps
// Overview of operation
// - Result equals channel over reference scaled to 255, by bitwise search.
// - With auto sampling set, timer strobe edges start conversions.
// - Strobe edges while busy are dropped, never queued.
// - A detected auto trigger sets the busy bit.
// - Auto conversions wait one conversion cycle before the first phase.
// - After eight bits are stored, done flag sets and interrupt may fire.
// - Busy clears only after every phase, possibly after done.
// - Effective configuration is frozen while a conversion runs.
// - Software mode clocks conversion from the instruction clock.
// - Auto mode clocks conversion from the timer clock, aligned to strobe.
// - Divider setting 3 divides by eight in software mode; fast clock modes divide more.
// - Divider setting 1 divides by two in software mode; higher settings divide more.
// - Auto mode divide factor comes from fast mode bits, not prescale.
// - Auto mode at upper oscillator speed needs divider setting of one.
// - Autozero conversion: 6 offset, 5 gain correction, 9 convert cycles.
// - Opamp enable bit switches on the uncommitted amplifier.
// - Current source enable bit starts current on its pin.
// - Standard conversion: 4 sample cycles then 9 convert cycles.
// - Writing the start bit starts a conversion in software mode; it reads high meanwhile.
// - Autozero enable is latched at the trigger and held.
module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        instr_clk_tick,
    input  wire logic        timer_clk_tick,
    input  wire logic        timer_sample_strobe,
    input  wire logic        cmp_above,
    output logic [7:0]       dac_code,
    output logic [2:0]       channel_select,
    output logic             sample_hold,
    output logic             offset_phase,
    output logic             gain_phase,
    output logic             autozero_amp_en,
    output logic             opamp_enable,
    output logic             current_source_enable,
    output logic             conversion_busy,
    output logic             done_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        busy_r;
    logic        done_r;
    logic        ie_r;
    logic [2:0]  ch_r;
    logic [5:0]  ctrl2_r;
    logic [5:0]  tpre_r;
    logic [7:0]  result_r;
    logic [7:0]  sar_r;
    logic [4:0]  cnt_r;
    acs_cfg_s    cfg_r;
    acs_state_e  state_r;
    acs_state_e  state_nxt;
    logic        strb_s1_r;
    logic        strb_s2_r;
    logic        strb_s3_r;
    logic        sample_hold_r;
    logic        offset_phase_r;
    logic        gain_phase_r;
    logic        opamp_en_r;
    logic        isrc_en_r;
    logic        done_irq_r;
    logic        tick;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.
    wire       setup_ph  = psel && !penable;
    wire       access_ph = psel && penable;
    wire       fire      = access_ph && pready_r;
    wire       wr_fire   = fire && pwrite;
    wire       sel_c1    = (paddr == ACS_OFF_CTRL1);
    wire       sel_c2    = (paddr == ACS_OFF_CTRL2);
    wire       sel_res   = (paddr == ACS_OFF_RESULT);
    wire       sel_tp    = (paddr == ACS_OFF_TPRE);
    wire       mapped    = sel_c1 || sel_c2 || sel_res || sel_tp;
    wire       wr_c1     = wr_fire && sel_c1;
    wire       wr_c2     = wr_fire && sel_c2;
    wire       wr_tp     = wr_fire && sel_tp;
    wire [7:0] c1_rd     = {2'b00, ch_r, ie_r, done_r, busy_r};
    wire [7:0] rd_byte   = sel_c1  ? c1_rd :
                           sel_c2  ? {2'b00, ctrl2_r} :
                           sel_res ? result_r :
                           sel_tp  ? {2'b00, tpre_r} : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Triggers and effective configuration.
    // strobe edge pulse
    wire strb_rise = strb_s2_r && !strb_s3_r;
    wire auto_sw   = ctrl2_r[ACS_C2_AUTO];
    wire sw_trig   = wr_c1 && pwdata[ACS_C1_BUSY] && !auto_sw && !busy_r;
    wire auto_trig = strb_rise && auto_sw && !busy_r;
    wire trig      = sw_trig || auto_trig;

    acs_cfg_s cur_cfg;
    assign cur_cfg = '{auto_mode: auto_sw,
                       az:        ctrl2_r[ACS_C2_AZ],
                       div:       ctrl2_r[ACS_C2_DIV +: 2],
                       fast_clock_mode:     tpre_r[ACS_TP_FAST_CLOCK_MODE],
                       fast_clock_select:      tpre_r[ACS_TP_FAST_CLOCK_SELECT],
                       fs:        tpre_r[ACS_TP_FS],
                       ch:        wr_c1 ? pwdata[ACS_C1_CH_LSB +: 3] : ch_r};

    wire src_tick = cfg_r.auto_mode ? timer_clk_tick : instr_clk_tick;
    wire [3:0] div_shift = acs_shift(cfg_r);

    acs_tick_div u_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (state_r == ACS_IDLE),
        .src_tick (src_tick),
        .shift    (div_shift),
        .tick_r   (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencing.
    wire       phase_end = tick && (cnt_r == acs_plen(state_r));
    wire [7:0] cur_bit   = ACS_SAR_MSB >> cnt_r[2:0];
    // keep the trial bit when the input is at or above it
    wire [7:0] sar_dec   = (cmp_above ? sar_r : (sar_r & ~cur_bit))
                           | (cur_bit >> 1);
    wire       store_ev  = (state_r == ACS_CONVERT) && phase_end;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ACS_IDLE: begin
                if (auto_trig) begin
                    state_nxt = ACS_DELAY;
                end else if (sw_trig) begin
                    state_nxt = cur_cfg.az ? ACS_OFFSET : ACS_SAMPLE;
                end
            end
            ACS_DELAY: begin
                if (tick) begin
                    state_nxt = cfg_r.az ? ACS_OFFSET : ACS_SAMPLE;
                end
            end
            ACS_OFFSET: begin
                if (phase_end) begin
                    state_nxt = ACS_GAINC;
                end
            end
            ACS_GAINC, ACS_SAMPLE: begin
                if (phase_end) begin
                    state_nxt = ACS_CONVERT;
                end
            end
            ACS_CONVERT: begin
                if (phase_end) begin
                    state_nxt = ACS_FINISH;
                end
            end
            // busy ends on the next instruction clock
            ACS_FINISH: begin
                if (instr_clk_tick) begin
                    state_nxt = ACS_IDLE;
                end
            end
            default: state_nxt = ACS_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ACS_IDLE;
            cnt_r   <= 5'h00;
            sar_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r) begin
                cnt_r <= 5'h00;
            end else if (tick) begin
                cnt_r <= 5'(cnt_r + 5'h01);
            end
            if (state_nxt == ACS_CONVERT && state_r != ACS_CONVERT) begin
                sar_r <= ACS_SAR_MSB;
            end else if (state_r == ACS_CONVERT && tick
                         && cnt_r < 5'h08) begin
                sar_r <= sar_dec;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers. Config writes during a conversion wait for the next one, except the opamp and current source enables.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            ie_r     <= 1'b0;
            ch_r     <= ACS_CH_RST;
            ctrl2_r  <= ACS_CTRL2_RST;
            tpre_r   <= ACS_TPRE_RST;
            result_r <= ACS_RESULT_RST;
            cfg_r    <= '0;
        end else begin
            // busy set on trigger, cleared after finish
            if (trig) begin
                busy_r <= 1'b1;
            end else if (state_r == ACS_FINISH && instr_clk_tick) begin
                busy_r <= 1'b0;
            end
            // done set wins over a clear
            if (store_ev) begin
                done_r <= 1'b1;
            end else if (wr_c1 && pwdata[ACS_C1_DONE]) begin
                done_r <= 1'b0;
            end
            if (wr_c1) begin
                ie_r <= pwdata[ACS_C1_IE];
                ch_r <= pwdata[ACS_C1_CH_LSB +: 3];
            end
            if (wr_c2) begin
                ctrl2_r <= pwdata[5:0];
            end
            if (wr_tp) begin
                tpre_r <= pwdata[5:0];
            end
            if (store_ev) begin
                result_r <= sar_r;
            end
            if (!busy_r) begin
                cfg_r <= cur_cfg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer, synchroniser and registered outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r       <= 32'h0000_0000;
            pready_r       <= 1'b0;
            pslverr_r      <= 1'b0;
            strb_s1_r      <= 1'b0;
            strb_s2_r      <= 1'b0;
            strb_s3_r      <= 1'b0;
            sample_hold_r  <= 1'b0;
            offset_phase_r <= 1'b0;
            gain_phase_r   <= 1'b0;
            opamp_en_r     <= 1'b0;
            isrc_en_r      <= 1'b0;
            done_irq_r     <= 1'b0;
        end else begin
            pready_r  <= access_ph && !pready_r;
            pslverr_r <= access_ph && !pready_r && !mapped;
            if (setup_ph) begin
                prdata_r <= {24'h00_0000, rd_byte};
            end
            strb_s1_r      <= timer_sample_strobe;
            strb_s2_r      <= strb_s1_r;
            strb_s3_r      <= strb_s2_r;
            sample_hold_r  <= (state_nxt == ACS_SAMPLE);
            offset_phase_r <= (state_nxt == ACS_OFFSET);
            gain_phase_r   <= (state_nxt == ACS_GAINC);
            opamp_en_r     <= ctrl2_r[ACS_C2_AMP];
            isrc_en_r      <= ctrl2_r[ACS_C2_ISRC];
            // interrupt request gated by its enable
            done_irq_r     <= done_r && ie_r;
        end
    end

    assign prdata                = prdata_r;
    assign pready                = pready_r;
    assign pslverr               = pslverr_r;
    assign dac_code              = sar_r;
    assign channel_select        = cfg_r.ch;
    assign sample_hold           = sample_hold_r;
    assign offset_phase          = offset_phase_r;
    assign gain_phase            = gain_phase_r;
    assign autozero_amp_en       = cfg_r.az;
    assign opamp_enable          = opamp_en_r;
    assign current_source_enable = isrc_en_r;
    assign conversion_busy       = busy_r;
    assign done_irq              = done_irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_busy_on_trig: assert property (trig |=> busy_r)
        else $error("busy not set after trigger");
    a_strobe_drop: assert property (
        busy_r && strb_rise && state_r != ACS_DELAY |=> state_r != ACS_DELAY)
        else $error("strobe restarted a running conversion");
    a_auto_delay: assert property (
        state_r == ACS_IDLE && auto_trig |=> state_r == ACS_DELAY)
        else $error("auto trigger skipped the delay cycle");
    a_sample_len: assert property (
        state_r == ACS_SAMPLE && tick |-> cnt_r < ACS_SH_CYC)
        else $error("sample phase too long");
    a_offset_gain: assert property (
        state_r == ACS_OFFSET && phase_end |=> state_r == ACS_GAINC
        ##0 cnt_r == 5'h00)
        else $error("offset phase did not hand over");
    a_done_store: assert property (
        store_ev |=> done_r && result_r == $past(sar_r))
        else $error("result or done flag not updated");
    a_busy_late: assert property (
        $fell(busy_r) |-> $past(state_r) == ACS_FINISH)
        else $error("busy cleared before all phases");
    a_cfg_frozen: assert property (
        busy_r && $past(busy_r) |-> $stable(cfg_r))
        else $error("configuration changed during conversion");
    a_az_latch: assert property (
        trig |=> autozero_amp_en == $past(ctrl2_r[ACS_C2_AZ]))
        else $error("autozero enable not latched at trigger");
endmodule

// [bench/acs_far_model.sv]
// Far-side model: clock tick sources, timer strobe and comparator.
`timescale 1ns/1ps
module acs_far_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       strobe_req,
    input  wire logic [7:0] vin,
    input  wire logic [7:0] dac_code,
    output logic            instr_clk_tick,
    output logic            timer_clk_tick,
    output logic            timer_sample_strobe,
    output logic            cmp_above
);
    logic [1:0] icnt_r;
    logic [2:0] tcnt_r;
    logic [2:0] hold_r;
    logic       pend_r;
    // Periods differ so a wrong tick source shows up in the counts.
    assign instr_clk_tick      = (icnt_r == 2'h3);
    assign timer_clk_tick      = (tcnt_r == 3'h4);
    assign timer_sample_strobe = (hold_r != 3'h0);
    assign cmp_above = (vin >= dac_code);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icnt_r <= 2'h0;
            tcnt_r <= 3'h0;
            hold_r <= 3'h0;
            pend_r <= 1'b0;
        end else begin
            icnt_r <= 2'(icnt_r + 2'h1);
            tcnt_r <= timer_clk_tick ? 3'h0 : 3'(tcnt_r + 3'h1);
            if (strobe_req) begin
                pend_r <= 1'b1;
            end
            // Strobe edge aligned to timer tick.
            if (pend_r && timer_clk_tick) begin
                pend_r <= 1'b0;
                hold_r <= 3'h4;
            end else if (hold_r != 3'h0) begin
                hold_r <= 3'(hold_r - 3'h1);
            end
        end
    end
endmodule

// [bench/acs_testbench.sv]
// Self-checking testbench of the conversion sequencer.
`timescale 1ns/1ps
module testbench;
    import acs_pkg::*;
    typedef struct packed {
        logic       am;
        logic       az;
        logic [2:0] ch;
        logic [15:0] lo;
        logic [15:0] hi;
    } acs_tb_cv_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, vin, dac;
    logic [31:0] pwdata, prdata;
    logic        itk, ttk, stb, cmp, stb_req, azen, open, isen;
    logic        busy, irq, busy_d, irq_d, sh, ofs, gn;
    logic [2:0]  chsel, seen;
    logic [32:0] rd_q[$];
    acs_tb_cv_s  cv_q[$];
    int          fail_count, n_tests, n_ins, n_tim;

    acs_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_clk_tick(itk), .timer_clk_tick(ttk),
        .timer_sample_strobe(stb), .cmp_above(cmp), .dac_code(dac),
        .channel_select(chsel), .sample_hold(sh), .offset_phase(ofs),
        .gain_phase(gn), .autozero_amp_en(azen), .opamp_enable(open),
        .current_source_enable(isen), .conversion_busy(busy),
        .done_irq(irq));
    acs_far_model far (.pclk(pclk), .presetn(presetn),
        .strobe_req(stb_req), .vin(vin), .dac_code(dac),
        .instr_clk_tick(itk), .timer_clk_tick(ttk),
        .timer_sample_strobe(stb), .cmp_above(cmp));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // An idle edge follows each transfer so no signal is driven twice.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            check(33'h0, 33'h1);
            stop_test();
        end
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rd_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_for(input logic v, input int bound);
        int k;
        k = 0;
        while (busy !== v && k < bound) begin
            @(posedge pclk);
            k++;
        end
        if (k >= bound) begin
            check({32'h0, busy}, {32'h0, v});
            stop_test();
        end
    endtask
    task automatic pulse();
        stb_req <= 1'b1;
        @(posedge pclk);
        stb_req <= 1'b0;
    endtask
    // Mid-run writes flip divider, autozero and channel to prove freezing.
    task automatic conv(input logic am, input logic az, input logic [2:0] tp,
                        input logic [1:0] div, input logic [2:0] ch);
        acs_tb_cv_s e;
        int         f, n, b;
        logic [7:0] v;
        v = 8'($urandom_range(0, 255));
        // Auto divide base: fast mode gives 2 or 3 by fs, else fast_clock_select gives 1.
        b = !am ? 0 : tp[0] ? (tp[2] ? 2 : 3) : int'(tp[1]);
        f = 1 << (int'(div) + b);
        n = (az ? 20 : 13) + int'(am);
        e = '{am, az, ch, 16'(n * f - f), 16'(n * f + 1)};
        vin <= v;
        apb(1'b1, ACS_OFF_TPRE, {29'h0, tp});
        apb(1'b1, ACS_OFF_CTRL2, {27'h0, am, div, 1'b0, az});
        cv_q.push_back(e);
        apb(1'b1, ACS_OFF_CTRL1, {26'h0, ch, 2'b10, ~am});
        if (am) pulse();
        wait_for(1'b1, 40);
        rd(ACS_OFF_CTRL1, {27'h0, ch, 3'b101});
        apb(1'b1, ACS_OFF_CTRL2, {27'h0, am, ~div, 1'b0, ~az});
        apb(1'b1, ACS_OFF_CTRL1, {26'h0, ~ch, 3'b100});
        if (am) pulse();
        wait_for(1'b0, 6000);
        rd(ACS_OFF_RESULT, {25'h0, v});
        apb(1'b1, ACS_OFF_CTRL1, {26'h0, ~ch, 3'b110});
        rd(ACS_OFF_CTRL1, {27'h0, ~ch, 3'b100});
        $display("conversion test am=%0d az=%0d div=%0d done", am, az, div);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0) begin
            check({pslverr, prdata}, rd_q.pop_front());
        end
    end
    always @(posedge pclk) begin
        acs_tb_cv_s e;
        busy_d <= busy;
        irq_d <= irq;
        if (busy === 1'b1 && busy_d !== 1'b1) begin
            n_ins = 0;
            n_tim = 0;
            seen = 3'h0;
        end else begin
            n_ins += int'(itk);
            n_tim += int'(ttk);
            seen = seen | {sh, ofs, gn};
        end
        if (irq === 1'b1 && irq_d !== 1'b1 && cv_q.size() > 0) begin
            e = cv_q.pop_front();
            check({31'h0, busy_d, azen}, {31'h0, 1'b1, e.az});
            check({30'h0, seen}, {30'h0, ~e.az, e.az, e.az});
            check({30'h0, chsel}, {30'h0, e.ch});
            check(33'((e.am ? n_tim : n_ins) inside {[e.lo:e.hi]}),
                  33'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        vin = 8'h00;
        stb_req = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        void'($urandom(6320));
        rd(ACS_OFF_CTRL1, {27'h0, ACS_CH_RST, 3'h0});
        rd(ACS_OFF_CTRL2, {27'h0, ACS_CTRL2_RST});
        rd(ACS_OFF_RESULT, {25'h0, ACS_RESULT_RST});
        rd(ACS_OFF_TPRE, {27'h0, ACS_TPRE_RST});
        rd(8'h10, 33'h1_0000_0000);
        apb(1'b1, ACS_OFF_RESULT, 32'hA5);
        apb(1'b1, ACS_OFF_TPRE, 32'h3F);
        rd(ACS_OFF_TPRE, 33'h3F);
        rd(ACS_OFF_RESULT, 33'h0);
        $display("register test done");
        conv(1'b0, 1'b0, 3'h0, 2'h0, 3'h2);
        conv(1'b0, 1'b1, 3'h0, 2'h1, 3'h1);
        conv(1'b0, 1'b0, 3'h0, 2'h3, 3'h5);
        conv(1'b1, 1'b0, 3'h0, 2'h0, 3'h0);
        conv(1'b1, 1'b1, 3'h2, 2'h1, 3'h3);
        conv(1'b1, 1'b0, 3'h1, 2'h1, 3'h4);
        for (int i = 0; i < 4; i++) begin
            conv(1'($urandom), 1'($urandom), 3'($urandom),
                 2'($urandom_range(0, 2)), 3'($urandom));
        end
        apb(1'b1, ACS_OFF_CTRL2, 32'h32);
        apb(1'b1, ACS_OFF_CTRL1, 32'h05);
        rd(ACS_OFF_CTRL1, 33'h04);
        check({31'h0, open, isen}, 33'h3);
        apb(1'b1, ACS_OFF_CTRL2, 32'h00);
        @(posedge pclk);
        check({31'h0, open, isen}, 33'h0);
        $display("enable test done");
        stop_test();
    end
endmodule
